// File: logic/socket_ident_status_power_regs.sv
// byte-wide identification, interface status and power control registers of the socket
`timescale 1ns/1ps
module socket_ident_status_power_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register access, byte wide
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // card interface
    input wire socket_regs_pkg::card_pins_t card_pins,
    input wire logic io_card_mode,
    // power switch and drivers
    output logic output_drivers_enable,
    output logic [1:0] vcc_level_request,
    output logic [1:0] vpp_level_request,
    output logic socket_power_on
);

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [1:0] emulation_q;
    logic [3:0] compat_revision_q;
    logic [7:0] power_q;
    logic [7:0] rdata_q;
    socket_regs_pkg::power_req_t req_q;

    socket_regs_pkg::power_req_t req_d;
    logic [7:0] status_byte;
    logic [7:0] ident_byte;
    logic [7:0] read_mux;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic hits(input logic [11:0] addr, input logic [11:0] offset);
        hits = (addr == offset);
    endfunction

    logic sel_ident;
    logic sel_status;
    logic sel_power;

    always_comb begin
        sel_ident = hits(reg_addr, socket_regs_pkg::IDENT_OFFSET);
        sel_status = hits(reg_addr, socket_regs_pkg::STATUS_OFFSET);
        sel_power = hits(reg_addr, socket_regs_pkg::POWER_OFFSET);
    end

    // ------------------------------------------------------------
    // identification and revision
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            emulation_q <= socket_regs_pkg::EMULATION_RESET;
            compat_revision_q <= socket_regs_pkg::COMPAT_REVISION_RESET;
        end else if (reg_wr && sel_ident) begin
            emulation_q <= reg_wdata[5:4];
            compat_revision_q <= reg_wdata[3:0];
        end
    end

    // interface kind is wired, never stored, so no write can reach it
    always_comb begin
        ident_byte = {socket_regs_pkg::INTERFACE_KIND, emulation_q, compat_revision_q};
    end

    // ------------------------------------------------------------
    // power control
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            power_q <= socket_regs_pkg::POWER_RESET;
        end else if (reg_wr && sel_power) begin
            power_q <= reg_wdata & socket_regs_pkg::POWER_WRITE_MASK;
        end
    end

    socket_power_decode u_power_decode (
        .power_byte(power_q),
        .req(req_d)
    );

    // requests leave through flops so the switch sees clean levels
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    always_comb begin
        output_drivers_enable = req_q.output_drivers_enable;
        vcc_level_request = req_q.vcc_level_request;
        vpp_level_request = req_q.vpp_level_request;
        socket_power_on = req_q.socket_power_on;
    end

    // ------------------------------------------------------------
    // interface status, live from the pins
    // ------------------------------------------------------------
    // power bit follows the programmed byte directly, not the delayed request
    socket_status_mux u_status_mux (
        .pins(card_pins),
        .io_card_mode(io_card_mode),
        .socket_power_on(req_d.socket_power_on),
        .status_byte(status_byte)
    );

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    // status writes are dropped: no register exists to take them
    always_comb begin
        read_mux = socket_regs_pkg::UNMAPPED_READ;
        case (1'b1)
            sel_ident: read_mux = ident_byte;
            sel_status: read_mux = status_byte;
            sel_power: read_mux = power_q;
            default: read_mux = socket_regs_pkg::UNMAPPED_READ;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= read_mux;
        end
    end

    always_comb begin
        reg_rdata = rdata_q;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_read_ident;
        reg_rd && sel_ident;
    endsequence

    sequence s_read_status;
        reg_rd && sel_status;
    endsequence

    sequence s_read_power;
        reg_rd && sel_power;
    endsequence

    sequence s_write_power;
        reg_wr && sel_power;
    endsequence

    sequence s_write_ident;
        reg_wr && sel_ident;
    endsequence

    AST_IDENT_KIND: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_ident |=> reg_rdata[7:6] == socket_regs_pkg::INTERFACE_KIND)
        else $error("interface kind field not 10b");

    // checked on the stored byte: the read path itself is covered by the kind check
    AST_IDENT_STORE: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_write_ident |=> ident_byte[5:4] == $past(reg_wdata[5:4]))
        else $error("emulation bits did not hold written value");

    AST_REV_STORE: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_write_ident |=> ident_byte[3:0] == $past(reg_wdata[3:0]))
        else $error("revision field did not hold written value");

    AST_STATUS_TOP: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_status |=> reg_rdata[7] == 1'b0)
        else $error("status bit 7 not zero");

    AST_STATUS_POWER: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_status |=> reg_rdata[6] == ($past(power_q[4:3]) == socket_regs_pkg::VCC_5V
            || $past(power_q[4:3]) == socket_regs_pkg::VCC_3V))
        else $error("socket power bit disagrees with power byte");

    AST_STATUS_READY: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_status |=> reg_rdata[5] == $past(card_pins.ready_pin))
        else $error("ready bit not following pin");

    AST_STATUS_WP: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_status |=> reg_rdata[4] == $past(card_pins.write_protect_pin))
        else $error("write protect bit not following pin");

    AST_STATUS_DETECT: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_status |=> reg_rdata[3:2] ==
            ~$past({card_pins.detect_pin_second, card_pins.detect_pin_first}))
        else $error("detect bits not inverted pins");

    AST_STATUS_BATTERY: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_read_status and !io_card_mode) |=> reg_rdata[1:0] ==
            $past({card_pins.battery_pin_second, card_pins.battery_pin_first}))
        else $error("battery bits not following pins");

    AST_STATUS_IO: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_read_status and io_card_mode) |=> reg_rdata[1:0] ==
            $past({card_pins.speaker_pin, card_pins.status_change_pin}))
        else $error("speaker and change bits not following pins");

    AST_RESET_POWER: assert property (@(posedge core_clk)
        $rose(rst_n) |-> power_q == socket_regs_pkg::POWER_RESET && !req_d.socket_power_on)
        else $error("power not off after reset");

    AST_DRIVERS: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_write_power ##1 !(reg_wr && sel_power)
        |=> output_drivers_enable == $past(reg_wdata[7], 2))
        else $error("driver enable not following written bit");

    AST_POWER_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
        s_read_power |=> (reg_rdata & ~socket_regs_pkg::POWER_WRITE_MASK) == 8'h00)
        else $error("reserved power bits read nonzero");

    AST_VCC_REQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_write_power and reg_wdata[4]) ##1 !(reg_wr && sel_power)
        |=> vcc_level_request == $past(reg_wdata[4:3], 2))
        else $error("vcc request not taken from power byte");

    AST_VPP_REQ: assert property (@(posedge core_clk) disable iff (!rst_n)
        (s_write_power and reg_wdata[4]) ##1 !(reg_wr && sel_power)
        |=> vpp_level_request == $past(reg_wdata[1:0], 2))
        else $error("vpp request not taken while vcc on");

    AST_VPP_GATED: assert property (@(posedge core_clk) disable iff (!rst_n)
        !socket_power_on |-> vpp_level_request == socket_regs_pkg::VPP_OFF)
        else $error("vpp requested while vcc off");

    AST_UNMAPPED: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd && !sel_ident && !sel_status && !sel_power)
        |=> reg_rdata == socket_regs_pkg::UNMAPPED_READ)
        else $error("unmapped address read nonzero");

    AST_STATUS_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_wr && sel_status) |=> $stable(power_q) && $stable(compat_revision_q)
            && $stable(emulation_q))
        else $error("status write changed stored state");

endmodule // socket_ident_status_power_regs

// File: logic/socket_power_decode.sv
// turns the programmed power byte into the requests the switch acts on
`timescale 1ns/1ps
module socket_power_decode (
    // programmed power byte
    input wire logic [7:0] power_byte,
    // decoded requests
    output socket_regs_pkg::power_req_t req
);
    logic [1:0] vcc_code;
    logic [1:0] vpp_code;
    logic vcc_on;

    always_comb begin
        vcc_code = power_byte[socket_regs_pkg::POWER_VCC_LSB +: 2];
        vpp_code = power_byte[socket_regs_pkg::POWER_VPP_LSB +: 2];
        // both 0 V codes, reserved one included, leave the socket unpowered
        vcc_on = (vcc_code == socket_regs_pkg::VCC_5V) || (vcc_code == socket_regs_pkg::VCC_3V);
        req.output_drivers_enable = power_byte[socket_regs_pkg::POWER_DRIVERS_BIT];
        req.vcc_level_request = vcc_on ? vcc_code : socket_regs_pkg::VCC_OFF;
        // vpp only counts while vcc is up
        req.vpp_level_request = vcc_on ? vpp_code : socket_regs_pkg::VPP_OFF;
        req.socket_power_on = vcc_on;
    end
endmodule // socket_power_decode

// File: logic/socket_regs_pkg.sv
// constants and carrier types for the socket identification, status and power registers
package socket_regs_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] IDENT_OFFSET = 12'h800;
    localparam logic [11:0] STATUS_OFFSET = 12'h801;
    localparam logic [11:0] POWER_OFFSET = 12'h802;

    // ------------------------------------------------------------
    // identification register layout
    // ------------------------------------------------------------
    localparam logic [1:0] INTERFACE_KIND = 2'h2;
    localparam logic [7:0] IDENT_WRITE_MASK = 8'h3F;
    // arbitrary value, stands in for the shipped revision code
    localparam logic [3:0] COMPAT_REVISION_RESET = 4'h1;
    localparam logic [1:0] EMULATION_RESET = 2'h0;

    // ------------------------------------------------------------
    // power control layout
    // ------------------------------------------------------------
    localparam logic [7:0] POWER_WRITE_MASK = 8'h9B;
    localparam logic [7:0] POWER_RESET = 8'h00;
    localparam int POWER_DRIVERS_BIT = 7;
    localparam int POWER_VCC_LSB = 3;
    localparam int POWER_VPP_LSB = 0;

    localparam logic [1:0] VCC_OFF = 2'h0;
    localparam logic [1:0] VCC_OFF_RSVD = 2'h1;
    localparam logic [1:0] VCC_5V = 2'h2;
    localparam logic [1:0] VCC_3V = 2'h3;

    localparam logic [1:0] VPP_OFF = 2'h0;
    localparam logic [1:0] VPP_VCC = 2'h1;
    localparam logic [1:0] VPP_12V = 2'h2;
    localparam logic [1:0] VPP_OFF_RSVD = 2'h3;

    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic detect_pin_second;
        logic detect_pin_first;
        logic ready_pin;
        logic write_protect_pin;
        logic battery_pin_second;
        logic battery_pin_first;
        logic speaker_pin;
        logic status_change_pin;
    } card_pins_t;

    typedef struct packed {
        logic output_drivers_enable;
        logic [1:0] vcc_level_request;
        logic [1:0] vpp_level_request;
        logic socket_power_on;
    } power_req_t;

endpackage

// File: logic/socket_status_mux.sv
// assembles the live interface status byte from the card pins and the socket power state
`timescale 1ns/1ps
module socket_status_mux (
    // card side
    input wire socket_regs_pkg::card_pins_t pins,
    input wire logic io_card_mode,
    // power state
    input wire logic socket_power_on,
    // status byte
    output logic [7:0] status_byte
);
    always_comb begin
        status_byte = 8'h00;
        status_byte[7] = 1'b0;
        status_byte[6] = socket_power_on;
        status_byte[5] = pins.ready_pin;
        status_byte[4] = pins.write_protect_pin;
        status_byte[3] = ~pins.detect_pin_second;
        status_byte[2] = ~pins.detect_pin_first;
        if (io_card_mode) begin
            status_byte[1] = pins.speaker_pin;
            status_byte[0] = pins.status_change_pin;
        end else begin
            status_byte[1] = pins.battery_pin_second;
            status_byte[0] = pins.battery_pin_first;
        end
    end
endmodule // socket_status_mux

// File: testbench/card_model.sv
// behavioural removable card seen from the socket pins
`timescale 1ns/1ps
module card_model (
    // commanded card state
    input wire logic seat_first,
    input wire logic seat_second,
    input wire logic io_card,
    input wire logic ready,
    input wire logic wp,
    input wire logic [1:0] bat,
    input wire logic spk,
    input wire logic chg,
    // socket pins
    output socket_regs_pkg::card_pins_t card_pins,
    output logic io_card_mode
);
    // ------------------------------------------------------------
    // pin levels
    // ------------------------------------------------------------
    // detect pins pull low once seated; unused pins carry the inverse so a wrong select shows
    always_comb begin
        card_pins.detect_pin_first = ~seat_first;
        card_pins.detect_pin_second = ~seat_second;
        card_pins.ready_pin = ready;
        card_pins.write_protect_pin = wp;
        card_pins.battery_pin_second = io_card ? ~spk : bat[1];
        card_pins.battery_pin_first = io_card ? ~chg : bat[0];
        card_pins.speaker_pin = io_card ? spk : ~bat[1];
        card_pins.status_change_pin = io_card ? chg : ~bat[0];
        io_card_mode = io_card;
    end
endmodule // card_model

// File: testbench/testbench.sv
// self-checking bench for the socket ident, status and power registers
`timescale 1ns/1ps
module testbench;
    // ------------------------------------------------------------
    // stimulus and observation
    // ------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic s1 = 1'b1, s2 = 1'b1, io = 1'b0, rdy = 1'b0, wp = 1'b0, spk = 1'b0, chg = 1'b0;
    logic [1:0] bat = 2'h0;
    socket_regs_pkg::card_pins_t pins;
    logic io_mode, drv, on;
    logic [1:0] vcc, vpp;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #12.5 core_clk = ~core_clk;

    card_model card (.seat_first(s1), .seat_second(s2), .io_card(io), .ready(rdy), .wp(wp),
        .bat(bat), .spk(spk), .chg(chg), .card_pins(pins), .io_card_mode(io_mode));

    socket_ident_status_power_regs dut (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .card_pins(pins), .io_card_mode(io_mode),
        .output_drivers_enable(drv), .vcc_level_request(vcc), .vpp_level_request(vpp),
        .socket_power_on(on));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // a hung handshake would otherwise run forever
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] d;
        rd(12'h800, d);
        chk(d, {2'b10, 2'b00, socket_regs_pkg::COMPAT_REVISION_RESET});
        rd(12'h802, d);
        chk(d, 8'h00);
        chk({drv, on, vcc, vpp, 2'b00}, 8'h00);
        rd(12'h801, d);
        chk(d, 8'h0C);
        $display("reset values done");
    endtask

    task automatic t_ident;
        logic [7:0] d;
        wr(12'h800, 8'hFF);
        rd(12'h800, d);
        chk(d, 8'hBF);
        wr(12'h800, 8'h5A);
        rd(12'h800, d);
        chk(d, 8'h9A);
        wr(12'h800, 8'h00);
        rd(12'h800, d);
        chk(d, 8'h80);
        $display("ident register done");
    endtask

    task automatic t_power;
        logic [7:0] d;
        logic [1:0] cv, cp;
        logic ce, up;
        for (int i = 0; i < 16; i++) begin
            cv = i[3:2];
            cp = i[1:0];
            ce = i[0] ^ i[2];
            up = cv[1];
            wr(12'h802, {ce, 2'b11, cv, 1'b1, cp});
            repeat (2) @(posedge core_clk);
            #1;
            chk({7'h00, drv}, {7'h00, ce});
            chk({6'h00, vcc}, {6'h00, (cv == 2'h1) ? 2'h0 : cv});
            chk({6'h00, vpp}, {6'h00, up ? cp : 2'h0});
            chk({7'h00, on}, {7'h00, up});
            rd(12'h802, d);
            chk(d, {ce, 2'b00, cv, 1'b0, cp});
            rd(12'h801, d);
            chk({7'h00, d[6]}, {7'h00, up});
        end
        wr(12'h802, 8'h00);
        $display("power control done");
    endtask

    task automatic t_status;
        logic [7:0] d;
        for (int i = 0; i < 20; i++) begin
            @(posedge core_clk);
            io <= (i >= 16);
            s1 <= i[0];
            s2 <= i[1];
            bat <= i[3:2];
            rdy <= i[1] ^ i[3];
            wp <= i[0] ^ i[2];
            spk <= i[1];
            chg <= i[0] ^ i[1];
            rd(12'h801, d);
            chk(d, {2'b00, rdy, wp, s2, s1, io ? {spk, chg} : bat});
            wr(12'h801, 8'hFF);
            rd(12'h801, d);
            chk(d, {2'b00, rdy, wp, s2, s1, io ? {spk, chg} : bat});
        end
        $display("interface status done");
    endtask

    task automatic t_map;
        logic [7:0] d;
        wr(12'h803, 8'hFF);
        wr(12'h000, 8'hFF);
        rd(12'h803, d);
        chk(d, 8'h00);
        rd(12'h000, d);
        chk(d, 8'h00);
        rd(12'h800, d);
        chk(d, 8'h80);
        rd(12'h802, d);
        chk(d, 8'h00);
        chk({drv, on, vcc, vpp, 2'b00}, 8'h00);
        $display("address map done");
    endtask

    // reset in mid-run must drop written state, ident and power alike
    task automatic t_rereset;
        logic [7:0] d;
        wr(12'h800, 8'h3F);
        wr(12'h802, 8'h9B);
        rd(12'h801, d);
        chk({7'h00, d[6]}, 8'h01);
        @(posedge core_clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(12'h800, d);
        chk(d, {2'b10, 2'b00, socket_regs_pkg::COMPAT_REVISION_RESET});
        rd(12'h802, d);
        chk(d, 8'h00);
        chk({drv, on, vcc, vpp, 2'b00}, 8'h00);
        rd(12'h801, d);
        chk(d, {2'b00, rdy, wp, s2, s1, io ? {spk, chg} : bat});
        $display("reset again done");
    endtask

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        t_reset();
        t_ident();
        t_power();
        t_status();
        t_map();
        t_rereset();
        end_of_test();
    end
endmodule // testbench
